/* File: include/bbs_pkg.sv */
package bbs_pkg;
   // ==========================================================
   // Opcode fields
   // ==========================================================
   localparam int           OPC_W           = 16;
   localparam int           PC_W            = 21;
   localparam int           ADDR_W          = 12;
   localparam logic [3:0]   OP_BRANCH_TOP   = 4'hd;   // 1101 then 0
   localparam logic [3:0]   OP_SET_BIT      = 4'h8;   // 1000
   localparam logic [3:0]   OP_TEST_CLR     = 4'hb;   // 1011
   localparam int           OFFS_MSB        = 10;
   localparam int           BIT_LSB         = 9;
   localparam int           BANKSEL_POS     = 8;
   localparam logic [3:0]   ACCESS_BANK_LO  = 4'h0;
   localparam logic [3:0]   ACCESS_BANK_HI  = 4'hf;
   localparam logic [7:0]   ACCESS_SPLIT    = 8'h80;
   localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;
   localparam logic [PC_W-1:0] PC_RESET     = 21'h000000;
   // Two-word instructions start with 1100 or any of 1110_1100 to 1110_1111
   localparam logic [3:0]   OP_MOVE_PAIR    = 4'hc;
   localparam logic [7:0]   OP_CALL_LO      = 8'hec;
   localparam logic [7:0]   OP_CALL_HI      = 8'hed;
   localparam logic [7:0]   OP_LOAD_PTR     = 8'hee;
   localparam logic [7:0]   OP_GOTO         = 8'hef;

   // Data-memory access request
   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } mem_req_t;
endpackage

/* File: hw/bank_addr.sv */
`timescale 1ns/10ps
// ==========================================================
// Data address forming from bank bit and bank register
// ==========================================================
module bank_addr
(
   input  wire logic [7:0]              reg_addr_in,
   input  wire logic                    bank_sel_in,
   input  wire logic [3:0]              bank_select_register_in,
   output logic [bbs_pkg::ADDR_W-1:0]   addr_out
);
   // Low half of the access bank maps to bank 0, upper half to the top
   wire logic [3:0] access_bank;
   assign access_bank = (reg_addr_in < bbs_pkg::ACCESS_SPLIT)
                        ? bbs_pkg::ACCESS_BANK_LO : bbs_pkg::ACCESS_BANK_HI;
   // Bank bit clear ignores the bank register entirely
   assign addr_out = bank_sel_in
                     ? {bank_select_register_in, reg_addr_in}
                     : {access_bank, reg_addr_in};
endmodule

/* File: hw/branch_bitset_skip_exec.sv */
`timescale 1ns/10ps
// One call of this block per instruction cycle: q_tick_in marks the
// Q4 edge of the core's four-phase cycle, where results commit.
module branch_bitset_skip_exec
(
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      q_tick_in,
   input  wire logic [15:0]               opcode_in,
   input  wire logic [15:0]               prefetch_in,
   input  wire logic [3:0]                bank_select_register_in,
   input  wire logic [7:0]                rdata_in,
   input  wire logic [4:0]                status_in,
   output bbs_pkg::mem_req_t              mem_out,
   output logic [bbs_pkg::PC_W-1:0]       pc_out,
   output logic                           no_operation_out,
   output logic                           flush_out,
   output logic [4:0]                     status_out
);
   // ==========================================================
   // Decode
   // ==========================================================
   typedef enum logic [1:0] {S_EXEC, S_IDLE1, S_IDLE2} state_t;
   state_t                      state_reg;
   state_t                      state_next;
   logic [bbs_pkg::PC_W-1:0]    pc_reg;
   logic [bbs_pkg::PC_W-1:0]    pc_next;

   wire logic                        is_branch_always;
   wire logic                        is_set_register_bit;
   wire logic                        is_test_bit_skip_if_zero;
   wire logic [2:0]                  bit_idx;
   wire logic [7:0]                  bit_mask;
   wire logic                        tested_bit;
   wire logic                        skip_taken;
   wire logic                        next_two_word;
   wire logic                        executing;
   wire logic [bbs_pkg::ADDR_W-1:0]  data_addr;
   wire logic [bbs_pkg::PC_W-1:0]    offs_x2;

   function automatic logic two_word(input logic [15:0] op);
      two_word = (op[15:12] == bbs_pkg::OP_MOVE_PAIR)
              || (op[15:8] == bbs_pkg::OP_CALL_LO)
              || (op[15:8] == bbs_pkg::OP_CALL_HI)
              || (op[15:8] == bbs_pkg::OP_LOAD_PTR)
              || (op[15:8] == bbs_pkg::OP_GOTO);
   endfunction

   assign executing = (state_reg == S_EXEC);
   assign is_branch_always = executing
      && (opcode_in[15:12] == bbs_pkg::OP_BRANCH_TOP)
      && !opcode_in[11];
   assign is_set_register_bit = executing
      && (opcode_in[15:12] == bbs_pkg::OP_SET_BIT);
   assign is_test_bit_skip_if_zero = executing
      && (opcode_in[15:12] == bbs_pkg::OP_TEST_CLR);
   assign bit_idx  = opcode_in[bbs_pkg::BIT_LSB +: 3];
   assign bit_mask = 8'h01 << bit_idx;
   assign tested_bit = |(rdata_in & bit_mask);
   assign skip_taken = is_test_bit_skip_if_zero && !tested_bit;
   // Only the prefetched word is seen: a stale prefetch at the test's
   // tick would discard the wrong number of words
   assign next_two_word = two_word(prefetch_in);

   // Sign-extended offset doubled: word-aligned program counter
   assign offs_x2 = {{(bbs_pkg::PC_W-12){opcode_in[bbs_pkg::OFFS_MSB]}},
                     opcode_in[bbs_pkg::OFFS_MSB:0], 1'b0};

   bank_addr u_bank
   (
      .reg_addr_in             (opcode_in[7:0]),
      .bank_sel_in             (opcode_in[bbs_pkg::BANKSEL_POS]),
      .bank_select_register_in (bank_select_register_in),
      .addr_out                (data_addr)
   );

   // ==========================================================
   // Memory read-modify-write, single cycle
   // ==========================================================
   assign mem_out.rd    = is_set_register_bit || is_test_bit_skip_if_zero;
   assign mem_out.wr    = is_set_register_bit && q_tick_in;
   assign mem_out.addr  = data_addr;
   assign mem_out.wdata = rdata_in | bit_mask;
   // Flags pass straight through: none of these touch them
   assign status_out    = status_in;

   // ==========================================================
   // Sequencer and program counter
   // ==========================================================
   always_comb
   begin
      state_next = state_reg;
      pc_next    = pc_reg;
      if (q_tick_in)
      begin
         case (state_reg)
            S_EXEC:
            begin
               if (is_branch_always)
               begin
                  // pc_reg already points past the branch word
                  pc_next    = pc_reg + offs_x2;
                  state_next = S_IDLE2;
               end
               else if (skip_taken)
               begin
                  pc_next    = pc_reg + bbs_pkg::PC_STEP;
                  state_next = next_two_word ? S_IDLE1 : S_IDLE2;
               end
               else
               begin
                  pc_next = pc_reg + bbs_pkg::PC_STEP;
               end
            end
            S_IDLE1:
            begin
               // Second word of a skipped pair also dropped
               pc_next    = pc_reg + bbs_pkg::PC_STEP;
               state_next = S_IDLE2;
            end
            S_IDLE2:
            begin
               pc_next    = pc_reg + bbs_pkg::PC_STEP;
               state_next = S_EXEC;
            end
            default: state_next = S_EXEC;
         endcase
      end
   end

   // Commit on the Q4 tick only
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= S_EXEC;
         pc_reg    <= bbs_pkg::PC_RESET;
      end
      else
      begin
         state_reg <= state_next;
         pc_reg    <= pc_next;
      end
   end

   assign pc_out = pc_reg;
   // Idle cycles replace the discarded fetch with a no-operation
   assign no_operation_out = !executing;
   assign flush_out = q_tick_in && (is_branch_always || skip_taken);

   // ==========================================================
   // Checks
   // ==========================================================
   // Branch target rebuilt from the opcode bits themselves
   a_branch_target: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && is_branch_always |=> pc_out == $past(pc_out)
      + {{(bbs_pkg::PC_W-12){$past(opcode_in[10])}},
         $past(opcode_in[10:0]), 1'b0})
      else $error("branch target wrong");
   a_branch_idle: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && is_branch_always |=> no_operation_out && !flush_out)
      else $error("branch second cycle not idle");
   a_idle_end: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && state_reg == S_IDLE2 |=> !no_operation_out)
      else $error("idle cycle did not end");
   a_skip_flush: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && is_test_bit_skip_if_zero
      && !rdata_in[opcode_in[11:9]] |-> flush_out)
      else $error("clear bit not skipped");
   a_no_skip_set: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      is_test_bit_skip_if_zero && tested_bit |-> !flush_out)
      else $error("skip on set bit");
   a_skip_idle: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && skip_taken |=> no_operation_out)
      else $error("skip did not discard");
   a_skip_one_word: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && skip_taken && !next_two_word |=> state_reg == S_IDLE2)
      else $error("one-word skip wrong length");
   // A discarded word must neither touch memory nor redirect the core
   a_idle_quiet: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      no_operation_out |-> !mem_out.rd && !mem_out.wr && !flush_out)
      else $error("discarded word acted");
   a_skip_two_word: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      q_tick_in && skip_taken && next_two_word |=> state_reg == S_IDLE1)
      else $error("two-word skip too short");
   a_access_bank: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      mem_out.rd && !opcode_in[bbs_pkg::BANKSEL_POS] |->
      mem_out.addr == {(opcode_in[7] ? 4'hf : 4'h0), opcode_in[7:0]})
      else $error("access bank wrong");
   a_bank_reg: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      mem_out.rd && opcode_in[bbs_pkg::BANKSEL_POS] |->
      mem_out.addr == {bank_select_register_in, opcode_in[7:0]})
      else $error("bank register ignored");
   a_bit_set: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      mem_out.wr |-> is_set_register_bit && q_tick_in
      && mem_out.wdata == (rdata_in | (8'h01 << opcode_in[11:9])))
      else $error("bit not set");
   a_flags_kept: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      is_branch_always || is_test_bit_skip_if_zero || is_set_register_bit
      |-> status_out == status_in)
      else $error("flags changed");
   // Main scenarios, including a branch word that arrives while idle
   c_branch: cover property (@(posedge clk_in) q_tick_in && is_branch_always);
   c_skip: cover property (@(posedge clk_in) q_tick_in && skip_taken);
   c_skip2: cover property (@(posedge clk_in)
      q_tick_in && skip_taken && next_two_word);
   c_set: cover property (@(posedge clk_in) mem_out.wr);
   c_idle_ignored: cover property (@(posedge clk_in)
      q_tick_in && no_operation_out
      && opcode_in[15:12] == bbs_pkg::OP_BRANCH_TOP);
endmodule

/* File: testbench/test_branch_bitset_skip_exec.sv */
`timescale 1ns/10ps
// One compare: counts it, reports a mismatch at once
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
   err_count++; $display("wrong value at %0t: %h %h", $time, got, exp); \
   end end
module test_branch_bitset_skip_exec;
   // ==========================================================
   // Stimulus and observed signals
   // ==========================================================
   logic                     clk_in = 1'b0;
   logic                     rst_n_in = 1'b0;
   logic                     q_tick_in = 1'b0;
   logic [15:0]              opcode_in = 16'h0000;
   logic [15:0]              prefetch_in = 16'h0000;
   logic [3:0]               bank_select_register_in = 4'h0;
   logic [7:0]               rdata_in = 8'h00;
   logic [4:0]               status_in = 5'h00;
   bbs_pkg::mem_req_t        mem_out;
   logic [bbs_pkg::PC_W-1:0] pc_out;
   logic                     no_operation_out;
   logic                     flush_out;
   logic [4:0]               status_out;
   logic [20:0]              pc_exp = 21'h000000;
   int                       err_count = 0;
   int                       tests_run = 0;
   int                       seed = 23750;
   int                       idle = 0;
   int                       k;

   branch_bitset_skip_exec i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .q_tick_in(q_tick_in), .opcode_in(opcode_in),
      .prefetch_in(prefetch_in),
      .bank_select_register_in(bank_select_register_in),
      .rdata_in(rdata_in), .status_in(status_in), .mem_out(mem_out),
      .pc_out(pc_out), .no_operation_out(no_operation_out),
      .flush_out(flush_out), .status_out(status_out));

   // Free-running 10 MHz core clock
   initial
   begin
      forever #50 clk_in = ~clk_in;
   end

   // ==========================================================
   // Expectation helpers
   // ==========================================================
   function automatic logic [11:0] exp_addr(logic [15:0] op,
                                            logic [3:0] bank_select_register);
      if (op[8])
         return {bank_select_register, op[7:0]};
      return {(op[7:0] < 8'h80) ? 4'h0 : 4'hf, op[7:0]};
   endfunction

   function automatic logic two_word(logic [15:0] w);
      return (w[15:12] == 4'hc) || (w[15:10] == 6'b111011);
   endfunction

   // One tick; ticks stay back to back unless a gap is asked for
   task automatic issue(input logic [15:0] op, input logic [15:0] pre,
                        input logic [7:0] rd);
      logic [20:0] off;
      logic        zb;
      @(negedge clk_in);
      opcode_in = op;
      prefetch_in = pre;
      rdata_in = rd;
      bank_select_register_in = 4'($random(seed));
      status_in = 5'($random(seed));
      q_tick_in = 1'b1;
      #1;
      zb = ~rd[op[11:9]];
      `CHK(status_out, status_in)
      `CHK(no_operation_out, idle != 0)
      if (idle != 0)
      begin
         `CHK({flush_out, mem_out.wr, mem_out.rd}, 3'b000)
         idle--;
         pc_exp += 21'h2;
      end
      else if (op[15:11] == 5'b11010)
      begin
         off = {{10{op[10]}}, op[10:0]};
         pc_exp = pc_exp + (off << 1);
         `CHK({flush_out, mem_out.wr, mem_out.rd}, 3'b100)
         idle = 1;
      end
      else
      begin
         `CHK(mem_out.addr, exp_addr(op, bank_select_register_in))
         `CHK(mem_out.rd, 1'b1)
         pc_exp += 21'h2;
         if (op[15:12] == 4'h8)
            `CHK({flush_out, mem_out.wr, mem_out.wdata},
                 {2'b01, rd | (8'h01 << op[11:9])})
         else
         begin
            `CHK({flush_out, mem_out.wr}, {zb, 1'b0})
            if (zb)
               idle = two_word(pre) ? 2 : 1;
         end
      end
      @(posedge clk_in);
      #1;
      `CHK(pc_out, pc_exp)
   endtask

   // Cycle without a tick: nothing commits, idle state stands
   task automatic gap();
      @(negedge clk_in);
      q_tick_in = 1'b0;
      #1;
      `CHK({flush_out, mem_out.wr, no_operation_out},
           {2'b00, idle != 0})
      @(posedge clk_in);
      #1;
      `CHK(pc_out, pc_exp)
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence: corners first, then random traffic
   // ==========================================================
   initial
   begin
      repeat (12) @(negedge clk_in);
      rst_n_in = 1'b1;
      `CHK({pc_out, no_operation_out}, 22'h000000)
      issue(16'hd400, 16'h1234, 8'h00); // Offset -1024
      issue(16'h0000, 16'h0000, 8'h00); // Idle slot after branch
      issue(16'hd3ff, 16'h1234, 8'h00); // Offset 1023
      issue(16'h0000, 16'h0000, 8'h00); // Idle slot after branch
      issue(16'h8f00, 16'h0000, 8'h0a); // Bit 7 of 0x0a
      issue(16'hb07f, 16'hc123, 8'hfe); // Skip over two words
      gap();
      issue(16'h0000, 16'h0000, 8'h00);
      issue(16'h0000, 16'h0000, 8'h00);
      issue(16'hb280, 16'hef00, 8'h02); // Bit set, no skip
      issue(16'hb380, 16'h1234, 8'h00); // Skip one word
      issue(16'hd000, 16'h0000, 8'h00);
      for (k = 0; k < 300; k++)
      begin
         case ({$random(seed)} % 3)
            0: issue({5'b11010, 11'($random(seed))}, 16'($random(seed)),
                     8'($random(seed)));
            1: issue({4'h8, 12'($random(seed))}, 16'($random(seed)),
                     8'($random(seed)));
            default: issue({4'hb, 12'($random(seed))},
                           16'($random(seed)), 8'($random(seed)));
         endcase
         if ({$random(seed)} % 4 == 0)
            gap();
      end
      // Reset again while a branch's idle cycle stands
      repeat (idle)
         issue(16'h0000, 16'h0000, 8'h00);
      issue(16'hd005, 16'h0000, 8'h00);
      @(negedge clk_in);
      q_tick_in = 1'b0;
      rst_n_in = 1'b0;
      #1;
      `CHK({pc_out, no_operation_out}, 22'h000000)
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      pc_exp = 21'h000000;
      idle = 0;
      issue(16'h8000, 16'h0000, 8'h00); // First tick after reset
      issue(16'hd7ff, 16'h0000, 8'h00); // Offset -1
      issue(16'h0000, 16'h0000, 8'h00); // Idle slot after branch
      tally_and_finish();
   end
endmodule
